// *** shared/iob_pkg.sv ***
// package of the isolated i/o card register bank
// assumes one byte-wide host i/o port and a single 10 mhz clock
package iob_pkg;

  // ==========================================================
  // widths
  localparam int unsigned IOB_AW = 16;
  localparam int unsigned IOB_DW = 8;

  // ==========================================================
  // register offsets from the assigned base address
  localparam logic [7:0] IOB_OFF_ENABLE   = 8'h00;
  localparam logic [7:0] IOB_OFF_SPDIR    = 8'h02;
  localparam logic [7:0] IOB_OFF_SPOUT    = 8'h03;
  localparam logic [7:0] IOB_OFF_IRQMASK  = 8'h05;
  localparam logic [7:0] IOB_OFF_SPSTATE  = 8'h07;
  localparam logic [7:0] IOB_OFF_IRQPOL   = 8'h2A;
  localparam logic [7:0] IOB_OFF_RELAY    = 8'hC0;
  localparam logic [7:0] IOB_OFF_INPUT    = 8'hC4;
  localparam logic [7:0] IOB_OFF_BOARDID  = 8'hF0;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned IOB_ENABLE_BIT  = 0;
  localparam logic [7:0]  IOB_RST_ENABLE  = 8'h00;
  localparam logic [7:0]  IOB_RST_SPDIR   = 8'h00;
  localparam logic [7:0]  IOB_RST_SPOUT   = 8'h00;
  localparam logic [7:0]  IOB_RST_IRQMASK = 8'h00;
  localparam logic [7:0]  IOB_RST_SPSTATE = 8'h00;
  localparam logic [7:0]  IOB_RST_IRQPOL  = 8'h00;
  localparam logic [7:0]  IOB_RST_RELAY   = 8'h00;
  localparam logic [7:0]  IOB_UNMAPPED    = 8'h00;

  // value is arbitrary, not tied to any real card
  localparam logic [7:0]  IOB_BOARD_ID    = 8'h5A;

  // ==========================================================
  // host i/o request, one cycle long
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [IOB_AW-1:0] addr;
    logic [IOB_DW-1:0] wdata;
  } iob_req_t;

  // read answer
  typedef struct packed {
    logic              valid;
    logic [IOB_DW-1:0] data;
  } iob_rsp_t;

endpackage : iob_pkg

// *** verilog/iob_sync2.sv ***
// two-stage synchroniser for a bus of pin levels
// assumes each bit is an independent level; no word coherence
`timescale 1ns/1ps
module iob_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================
  // stages
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : iob_sync2

// *** verilog/iob_regbank.sv ***
// register bank of the eight-input, eight-relay isolated i/o card
// assumes host i/o requests on sys_clk and a base address from configuration
//
// Functional notes
// - Every register is decoded as a byte offset from the configured base address.
// - The global enable bit comes up low and all input and relay activity is off while low.
// - Writing 1 to enable bit 0 turns input and relay output on, 0 turns it off, bits 7..1 reserved.
// - A direction bit of 0 makes its spare pin an input and 1 makes it an output.
// - All spare pin direction bits reset low so every spare pin starts as an input.
// - A spare pin set as output drives the matching bit of the spare pin output register.
// - A write at offset C0 sets the eight relay outputs, bit 0 to bit 7.
// - A read at offset C0 returns the inverse of the eight relay states.
// - Mask, spare pin state and polarity registers read back what was written.
`timescale 1ns/1ps
module iob_regbank (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic [iob_pkg::IOB_AW-1:0] base_addr,
  input  wire iob_pkg::iob_req_t       host_req,
  output iob_pkg::iob_rsp_t            host_rsp,
  input  wire logic [7:0]              isolated_inputs,
  input  wire logic [7:0]              spare_pin_bit_in,
  output logic      [7:0]              spare_pin_bit_out,
  output logic      [7:0]              spare_pin_bit_oe,
  output logic      [7:0]              relay_out,
  output logic                         io_enabled,
  output logic      [7:0]              irq_mask,
  output logic      [7:0]              irq_polarity
);

  import iob_pkg::*;

  // ==========================================================
  // helpers

  // offset of an address inside the card window, valid flag on top
  function automatic logic [8:0] offset_of(
    input logic [IOB_AW-1:0] addr,
    input logic [IOB_AW-1:0] base
  );
    logic [IOB_AW-1:0] diff;
    diff = addr - base;
    offset_of = {(diff[IOB_AW-1:8] == '0), diff[7:0]};
  endfunction : offset_of

  // true when a request hits a given offset
  function automatic logic hits(
    input logic [8:0] off,
    input logic [7:0] target
  );
    hits = off[8] && (off[7:0] == target);
  endfunction : hits

  // ==========================================================
  // state
  logic [7:0] enable_reg;
  logic [7:0] spdir_reg;
  logic [7:0] spout_reg;
  logic [7:0] irqmask_reg;
  logic [7:0] spstate_reg;
  logic [7:0] irqpol_reg;
  logic [7:0] relay_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic [7:0] rdata_next;
  logic [7:0] inputs_sync;
  logic [7:0] spare_sync;
  logic [8:0] req_off;
  logic       wr_go;
  logic       enabled;

  // ==========================================================
  // pin synchronisers
  iob_sync2 #(
    .WIDTH (16)
  ) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .ce       (ce),
    .async_in ({spare_pin_bit_in, isolated_inputs}),
    .sync_out ({spare_sync, inputs_sync})
  );

  // ==========================================================
  // decode
  // base relative decode
  assign req_off = offset_of(host_req.addr, base_addr);
  assign wr_go   = ce && host_req.wr;
  assign enabled = enable_reg[IOB_ENABLE_BIT];

  // ==========================================================
  // global enable
  // enable bit only, reserved bits stay zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enable_reg <= IOB_RST_ENABLE;
    end else if (wr_go && hits(req_off, IOB_OFF_ENABLE)) begin
      enable_reg <= {7'h00, host_req.wdata[IOB_ENABLE_BIT]};
    end
  end

  // ==========================================================
  // spare pins
  // direction register, inputs after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spdir_reg <= IOB_RST_SPDIR;
    end else if (wr_go && hits(req_off, IOB_OFF_SPDIR)) begin
      spdir_reg <= host_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spout_reg <= IOB_RST_SPOUT;
    end else if (wr_go && hits(req_off, IOB_OFF_SPOUT)) begin
      spout_reg <= host_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spstate_reg <= IOB_RST_SPSTATE;
    end else if (wr_go && hits(req_off, IOB_OFF_SPSTATE)) begin
      spstate_reg <= host_req.wdata;
    end
  end

  // drive only bits set as outputs
  assign spare_pin_bit_out = spout_reg & spdir_reg;
  assign spare_pin_bit_oe  = spdir_reg;

  // ==========================================================
  // interrupt setup storage, no interrupt logic lives here
  // mask readback
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqmask_reg <= IOB_RST_IRQMASK;
    end else if (wr_go && hits(req_off, IOB_OFF_IRQMASK)) begin
      irqmask_reg <= host_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqpol_reg <= IOB_RST_IRQPOL;
    end else if (wr_go && hits(req_off, IOB_OFF_IRQPOL)) begin
      irqpol_reg <= host_req.wdata;
    end
  end

  // ==========================================================
  // relays
  // relays drop while disabled so a disable is also a safe state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      relay_reg <= IOB_RST_RELAY;
    end else if (ce) begin
      if (!enabled) begin
        relay_reg <= IOB_RST_RELAY;
      end else if (host_req.wr && hits(req_off, IOB_OFF_RELAY)) begin
        relay_reg <= host_req.wdata;
      end
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rdata_next = IOB_UNMAPPED;
    if (hits(req_off, IOB_OFF_ENABLE)) begin
      rdata_next = enable_reg;
    end else if (hits(req_off, IOB_OFF_SPDIR)) begin
      rdata_next = spdir_reg;
    end else if (hits(req_off, IOB_OFF_SPOUT)) begin
      rdata_next = spout_reg;
    end else if (hits(req_off, IOB_OFF_IRQMASK)) begin
      rdata_next = irqmask_reg;
    end else if (hits(req_off, IOB_OFF_SPSTATE)) begin
      rdata_next = spstate_reg;
    end else if (hits(req_off, IOB_OFF_IRQPOL)) begin
      rdata_next = irqpol_reg;
    end else if (hits(req_off, IOB_OFF_RELAY)) begin
      rdata_next = ~relay_reg;
    end else if (hits(req_off, IOB_OFF_INPUT)) begin
      rdata_next = enabled ? inputs_sync : 8'h00;
    end else if (hits(req_off, IOB_OFF_BOARDID)) begin
      rdata_next = IOB_BOARD_ID;
    end
  end

  // one cycle read latency, valid is a single pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rvalid_reg <= host_req.rd;
      if (host_req.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ==========================================================
  // outputs
  assign host_rsp.valid = rvalid_reg;
  assign host_rsp.data  = rdata_reg;
  assign relay_out      = relay_reg;
  assign io_enabled     = enabled;
  assign irq_mask       = irqmask_reg;
  assign irq_polarity   = irqpol_reg;

  // spare pin level is synchronised but kept for a later status view
  logic unused_spare;
  assign unused_spare = ^spare_sync;

endmodule : iob_regbank

// *** tb/iob_monitor.sv ***
// checker of the isolated i/o register bank
// assumes only the bank's ports; bound below
`timescale 1ns/1ps
module iob_monitor (
  input wire logic                       sys_clk,
  input wire logic                       srst,
  input wire logic                       ce,
  input wire logic [iob_pkg::IOB_AW-1:0] base_addr,
  input wire iob_pkg::iob_req_t          host_req,
  input wire iob_pkg::iob_rsp_t          host_rsp,
  input wire logic [7:0]                 relay_out,
  input wire logic [7:0]                 spare_pin_bit_out,
  input wire logic [7:0]                 spare_pin_bit_oe,
  input wire logic                       io_enabled,
  input wire logic [7:0]                 irq_mask
);
  import iob_pkg::*;
  // ==========================================================
  // offset decode
  logic [15:0] off;
  logic        rd_ok;
  logic        wr_ok;
  assign off   = host_req.addr - base_addr;
  assign rd_ok = ce && host_req.rd;
  assign wr_ok = ce && host_req.wr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // assertions
  chk_read_pulse: assert property (
    rd_ok |=> host_rsp.valid) else $error("read answer missing");
  chk_no_spurious: assert property (
    ce && !host_req.rd |=> !host_rsp.valid) else $error("stray read answer");
  chk_relay_inverse: assert property (
    rd_ok && off == 16'h00C0 |=> host_rsp.data == ~$past(relay_out))
    else $error("relay readback wrong");
  chk_relay_set: assert property (
    wr_ok && io_enabled && off == 16'h00C0 |=> relay_out == $past(host_req.wdata))
    else $error("relay write lost");
  // a frozen cycle may keep the relays up one cycle longer
  chk_relay_off: assert property (
    !io_enabled && $past(!io_enabled) && $past(ce) |-> relay_out == 8'h00)
    else $error("relay on while off");
  chk_enable_set: assert property (
    wr_ok && off == 16'h0000 |=> io_enabled == $past(host_req.wdata[0]))
    else $error("enable write lost");
  chk_pin_gate: assert property (
    (spare_pin_bit_out & ~spare_pin_bit_oe) == 8'h00) else $error("input pin driven");
  chk_dir_store: assert property (
    wr_ok && off == 16'h0002 |=> spare_pin_bit_oe == $past(host_req.wdata))
    else $error("direction write lost");
  chk_reset_state: assert property (
    $past(srst) |-> spare_pin_bit_oe == 8'h00 && !io_enabled && relay_out == 8'h00)
    else $error("state after reset wrong");
  chk_mask_store: assert property (
    wr_ok && off == 16'h0005 |=> irq_mask == $past(host_req.wdata)) else $error("mask lost");
  chk_id_value: assert property (
    rd_ok && off == 16'h00F0 |=> host_rsp.data == IOB_BOARD_ID) else $error("id wrong");
  cover property (wr_ok && io_enabled && off == 16'h00C0);
  cover property (rd_ok && off == 16'h00F0);
  cover property (wr_ok && off == 16'h0000 ##1 io_enabled);
  cover property (!ce && host_req.wr);
endmodule : iob_monitor

bind iob_regbank iob_monitor mon (.sys_clk(sys_clk), .srst(srst), .ce(ce),
  .base_addr(base_addr), .host_req(host_req), .host_rsp(host_rsp), .relay_out(relay_out),
  .spare_pin_bit_out(spare_pin_bit_out), .spare_pin_bit_oe(spare_pin_bit_oe),
  .io_enabled(io_enabled), .irq_mask(irq_mask));

// *** tb/iob_host_model.sv ***
// host processor model issuing single byte i/o cycles
// assumes the bank answers a read within four cycles
`timescale 1ns/1ps
module iob_host_model (
  input  wire logic                       sys_clk,
  input  wire logic [iob_pkg::IOB_AW-1:0] base_addr,
  input  wire iob_pkg::iob_rsp_t          host_rsp,
  output iob_pkg::iob_req_t               host_req
);
  import iob_pkg::*;
  initial host_req = '0;
  task automatic xfer(input logic w, input logic [15:0] o, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    ok = w;
    q  = 8'h00;
    @(posedge sys_clk);
    host_req <= '{wr: w, rd: !w, addr: base_addr + o, wdata: d};
    @(posedge sys_clk);
    // released bus shows inverse, never a stale value
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~(base_addr + o), wdata: ~d};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      if (host_rsp.valid === 1'b1) begin
        q  = host_rsp.data;
        ok = 1'b1;
      end
    end
  endtask : xfer
endmodule : iob_host_model

// *** tb/tb.sv ***
// self-checking bench of the isolated i/o register bank
// assumes the host model makes every bank access
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== 8'(e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, 8'(e), g); end end
module tb;
  import iob_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] base_addr = 16'hA100;
  logic [7:0]  din, pin_in, q, relay_out, oe, sp_out, msk, pol;
  logic        en;
  iob_req_t    req;
  iob_rsp_t    rsp;
  int          failures = 0;
  int          checked = 0;
  int unsigned seed = 29183;
  int          mdl [int];
  bit          ok;
  // op table: kind (0 read, 1 write, 2 new pins), offset, data (-1 random)
  // kind 3 is a reset in mid-run, kind 4 a write while the clock enable is low
  int ops [41][3] = '{'{0,0,0}, '{0,2,0}, '{0,3,0}, '{0,5,0}, '{0,7,0}, '{0,'h2A,0},
    '{0,'hC0,0}, '{0,'hC4,0}, '{0,'hF0,0}, '{0,'h10,0}, '{0,'hFFFF,0}, '{1,'hC0,-1},
    '{0,'hC0,0}, '{1,0,'hFF}, '{0,0,0}, '{2,0,0}, '{0,'hC4,0}, '{1,'hC4,-1}, '{1,'hF0,-1},
    '{1,'h10,-1}, '{0,'hC4,0}, '{0,'hF0,0}, '{1,'hC0,-1}, '{0,'hC0,0}, '{1,'hC0,-1},
    '{0,'hC0,0}, '{4,'hC0,-1}, '{0,'hC0,0}, '{1,5,-1}, '{1,'h2A,-1}, '{1,7,-1}, '{1,2,-1},
    '{1,3,-1}, '{0,5,0}, '{0,'h2A,0}, '{0,7,0}, '{0,3,0}, '{1,0,0}, '{0,'hC4,0},
    '{3,0,0}, '{0,5,0}};
  always #50 sys_clk = ~sys_clk;
  iob_regbank dut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .base_addr(base_addr),
    .host_req(req), .host_rsp(rsp), .isolated_inputs(din), .spare_pin_bit_in(pin_in),
    .spare_pin_bit_out(sp_out), .spare_pin_bit_oe(oe), .relay_out(relay_out),
    .io_enabled(en), .irq_mask(msk), .irq_polarity(pol));
  iob_host_model host (.sys_clk(sys_clk), .base_addr(base_addr), .host_rsp(rsp),
    .host_req(req));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_rd(int o);
    if (o == 'hC0) return ~mdl['hC0] & 'hFF;
    if (o == 'hC4) return mdl[0] ? int'(din) : 0;
    if (o == 'hF0) return int'(IOB_BOARD_ID);
    return mdl.exists(o) ? mdl[o] : 0;
  endfunction : exp_rd
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic access(int w, int o, int d);
    host.xfer(w[0], 16'(o), 8'(d), q, ok);
    if (!ok) begin
      failures++;
      end_sim();
    end
    if (!w) `CHK($sformatf("read %h", o), exp_rd(o), q)
    else if (o == 'hC0 && mdl[0] != 0) mdl['hC0] = d & 'hFF;
    else if (o == 0) mdl[0] = d & 1;
    else if (o != 'hC0 && mdl.exists(o)) mdl[o] = d & 'hFF;
    if (mdl[0] == 0) mdl['hC0] = 0;
  endtask : access
  initial begin
    din = 8'(rnd());
    pin_in = 8'(rnd());
    foreach (ops[i]) mdl[ops[i][1]] = 0;
    mdl.delete('hC4);
    mdl.delete('hF0);
    mdl.delete('h10);
    mdl.delete('hFFFF);
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (ops[i]) begin
      if (ops[i][0] == 2) begin
        @(posedge sys_clk);
        din <= 8'(rnd());
        pin_in <= 8'(rnd());
        repeat (3) @(posedge sys_clk);
      end else if (ops[i][0] == 3) begin
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (mdl[k]) mdl[k] = 0;
      end else if (ops[i][0] == 4) begin
        // frozen cycle drops the write
        @(posedge sys_clk);
        ce <= 1'b0;
        host.xfer(1'b1, 16'(ops[i][1]), 8'(rnd()), q, ok);
        ce <= 1'b1;
      end else
        access(ops[i][0], ops[i][1], ops[i][2] < 0 ? int'(rnd() & 'hFF) : ops[i][2]);
      // relays drop one cycle after a disable
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("relay", mdl['hC0], relay_out)
      `CHK("enable", mdl[0], {7'h00, en})
      `CHK("mask", mdl[5], msk)
      `CHK("polarity", mdl['h2A], pol)
      `CHK("direction", mdl[2], oe)
      `CHK("drive", mdl[2] & mdl[3], sp_out)
    end
    end_sim();
  end
endmodule : tb
